// ---- sbsr_pkg.sv ----
// constants, command codes and the saved-settings layout of the status and state block
package sbsr_pkg;

    // command codes presented on the command port
    typedef enum logic [3:0] {
        CMD_RESET,      // return to known condition, command form only
        CMD_SAVE,       // save_state_command, slot in argument
        CMD_RECALL,     // recall_state_command, slot in argument
        CMD_MASK,       // request_mask_command write, or its query
        CMD_STATUS,     // status_summary_query
        CMD_CLEAR,      // clear_status_command
        CMD_INITIATE,   // immediate_initiate_command
        CMD_FETCH,      // fetch-type measurement query
        CMD_CONFIG      // load new saved-type settings from the settings port
    } sbsr_cmd_t;

    // acquisition engine view
    typedef enum logic [0:0] {
        ACQ_IDLE,
        ACQ_RUN
    } sbsr_acq_t;

    // settings that make up one saved instrument state
    typedef struct packed {
        logic        continuous;     // 0 single, 1 continuous acquisition
        logic        power_bar;      // power bar display on
        logic        std_air;        // 0 vacuum, 1 standard air
        logic        fast_update;    // 0 normal, 1 fast
        logic [2:0]  display_mode;   // display mode code
        logic [1:0]  freq_units;     // wavelength / frequency unit code
        logic [1:0]  power_units;    // power unit code
        logic [15:0] elevation;      // metres
        logic [7:0]  peak_excursion; // dB
        logic [7:0]  peak_threshold; // dB
        logic [7:0]  power_offset;   // dB, two's complement
        logic        snr_auto;       // signal-to-noise auto reference
        logic [15:0] snr_avg_count;  // signal-to-noise averages
        logic        wl_limit_en;    // wavelength range limiting
        logic [15:0] wl_start;       // nm
        logic [15:0] wl_stop;        // nm
    } sbsr_settings_t;

    // mode encodings
    localparam logic [2:0]  DISP_SINGLE_WL   = 3'h0;
    localparam logic [1:0]  UNIT_NM          = 2'h0;
    localparam logic [1:0]  UNIT_DBM         = 2'h0;

    // defaults loaded by the reset command
    localparam logic [15:0] DEF_WL_START     = 16'h04B0; // 1200 nm
    localparam logic [15:0] DEF_WL_STOP      = 16'h0672; // 1650 nm
    localparam logic [15:0] DEF_ELEVATION    = 16'h0000; // 0 m
    localparam logic [7:0]  DEF_POWER_OFFSET = 8'h00;    // 0 dB
    localparam logic [7:0]  DEF_PEAK_THRESH  = 8'h0A;    // 10 dB
    localparam logic [7:0]  DEF_PEAK_EXCUR   = 8'h0F;    // 15 dB
    localparam logic [15:0] DEF_SNR_AVG      = 16'h0064; // 100 averages
    localparam logic [15:0] DEF_SNR_USER_WL  = 16'h060E; // 1550 nm in vacuum
    localparam logic [15:0] DEF_UNCORR_PTS   = 16'h854B; // 34123 points
    localparam logic [15:0] DEF_DELTA_REF_WL = 16'h02BC; // 700 nm

    // slot argument range
    localparam logic [7:0]  SLOT_MIN         = 8'h01;
    localparam logic [7:0]  SLOT_MAX         = 8'h04;
    localparam int          SLOT_COUNT       = 4;

    // status byte and mask field positions
    localparam int          BIT_MSS          = 6;
    localparam int          BIT_ESB          = 5;
    localparam int          BIT_MAV          = 4;
    localparam int          BIT_ERRQ         = 2;
    localparam logic [7:0]  MASK_RESET       = 8'h00;

    // error codes returned on the answer port
    localparam logic [15:0] ERR_NONE         = 16'h0000;
    localparam logic [15:0] ERR_DATA_STALE   = 16'hFF1A; // -230
    localparam logic [15:0] ERR_ILLEGAL_FORM = 16'hFF8F; // -113
    localparam logic [15:0] ERR_OUT_OF_RANGE = 16'hFF22; // -222

endpackage

// ---- sbsr_status_state.sv ----
// status byte, service request mask, reset defaults and saved-state slots
//
// Operation
// - reset is command only; its query refused
// - reset: single acquisition, data invalid, fetch errors
// - save stores current state in slot 1-4
// - saved state holds all listed settings
// - reset loads display, limits, units, peak defaults
// - reset loads signal-to-noise defaults; address untouched
// - reset sets uncorrected data points to 34123
// - mask write takes 0..255 into 8-bit register
// - mask bit one lets status bit request service
// - mask cleared at power-on only, kept otherwise
// - mask query returns value with bit 6 zero
// - mask bits 5, 4, 2 meaningful
// - status byte layout: 6,5,4,2; others zero
// - bit 6 set when any service reason
// - status read returns weighted sum 0..255
// - status read never modifies any bit
// - recall restores state saved in slot 1-4
`timescale 1ns/1ps

module sbsr_status_state (
    input  wire logic                    mclk_i,            // 10 MHz system clock
    input  wire logic                    resetn_i,          // power-on reset, synchronous, active low
    input  wire logic                    cmd_valid_i,       // one-cycle command strobe
    input  wire sbsr_pkg::sbsr_cmd_t     cmd_code_i,        // decoded command
    input  wire logic                    cmd_query_i,       // command was sent in query form
    input  wire logic [7:0]              cmd_arg_i,         // integer argument
    input  wire sbsr_pkg::sbsr_settings_t cfg_i,            // settings to apply on a config command
    input  wire logic                    event_summary_i,   // summary from event status logic
    input  wire logic                    message_avail_i,   // output queue not empty
    input  wire logic                    error_queue_i,     // error queue not empty
    input  wire logic                    acq_done_i,        // measurement engine finished a sweep
    output logic                         resp_valid_o,      // one-cycle answer strobe
    output logic [15:0]                  resp_data_o,       // integer answer
    output logic [15:0]                  resp_err_o,        // zero or negative error code
    output logic                         srq_o,             // service request
    output logic                         acq_start_o,       // one-cycle sweep start
    output logic                         fetch_grant_o,     // one-cycle: fetch may read valid data
    output logic                         clear_status_o,    // one-cycle: clear event and error logic
    output sbsr_pkg::sbsr_settings_t     settings_o,        // current saved-type settings
    output logic                         graphics_o,        // graphical display on
    output logic [2:0]                   delta_mode_o,      // delta power, wavelength, both
    output logic [15:0]                  delta_ref_wl_o,    // delta reference position, nm
    output logic                         drift_o,           // drift measurement on
    output logic                         coherence_o,       // coherence measurement on
    output logic                         snr_meas_o,        // signal-to-noise measurement on
    output logic [15:0]                  snr_user_wl_o,     // user reference wavelength, nm
    output logic [15:0]                  uncorr_points_o,   // uncorrected acquisition points
    output logic                         data_valid_o       // held measurement data is valid
);

    // whole state of the block, registered in one place
    typedef struct packed {
        logic [7:0]                                  mask;       // service request mask
        logic                                        srq;        // registered master summary
        sbsr_pkg::sbsr_acq_t                         acq;        // acquisition state
        logic                                        data_valid; // measurement data valid
        sbsr_pkg::sbsr_settings_t                    cur;        // live settings
        sbsr_pkg::sbsr_settings_t [sbsr_pkg::SLOT_COUNT-1:0] slot; // saved states
        logic                                        graphics;
        logic [2:0]                                  delta_mode;
        logic [15:0]                                 delta_ref_wl;
        logic                                        drift;
        logic                                        coherence;
        logic                                        snr_meas;
        logic [15:0]                                 snr_user_wl;
        logic [15:0]                                 uncorr_points;
        logic                                        resp_valid;
        logic [15:0]                                 resp_data;
        logic [15:0]                                 resp_err;
        logic                                        acq_start;
        logic                                        fetch_grant;
        logic                                        clear_status;
    } sbsr_state_t;

    sbsr_state_t state;       // registered state
    sbsr_state_t next_state;  // combinational next state

    // compose the status byte from live inputs and the mask
    function automatic logic [7:0] sbsr_status_byte(input logic [7:0] mask,
                                                    input logic       event_summary_bit,
                                                    input logic       message_available_bit,
                                                    input logic       errq);
        logic [7:0] sb;
        sb                     = 8'h00;              // unused bits read zero
        sb[sbsr_pkg::BIT_ESB]  = event_summary_bit;
        sb[sbsr_pkg::BIT_MAV]  = message_available_bit;
        sb[sbsr_pkg::BIT_ERRQ] = errq;
        // a mask bit of one passes its status bit, zero blocks it
        sb[sbsr_pkg::BIT_MSS]  = |(sb & mask);
        return sb;
    endfunction

    // reset-command defaults for the saved-type settings
    function automatic sbsr_pkg::sbsr_settings_t sbsr_defaults();
        sbsr_pkg::sbsr_settings_t d;
        d                = '0;
        d.continuous     = 1'b0;                     // single acquisition
        d.power_bar      = 1'b1;
        d.std_air        = 1'b0;                     // vacuum calibration
        d.fast_update    = 1'b0;                     // normal speed
        d.display_mode   = sbsr_pkg::DISP_SINGLE_WL;
        d.freq_units     = sbsr_pkg::UNIT_NM;
        d.power_units    = sbsr_pkg::UNIT_DBM;
        d.elevation      = sbsr_pkg::DEF_ELEVATION;
        d.peak_excursion = sbsr_pkg::DEF_PEAK_EXCUR;
        d.peak_threshold = sbsr_pkg::DEF_PEAK_THRESH;
        d.power_offset   = sbsr_pkg::DEF_POWER_OFFSET;
        d.snr_auto       = 1'b1;                     // automatic reference
        d.snr_avg_count  = sbsr_pkg::DEF_SNR_AVG;
        d.wl_limit_en    = 1'b1;
        d.wl_start       = sbsr_pkg::DEF_WL_START;
        d.wl_stop        = sbsr_pkg::DEF_WL_STOP;
        return d;
    endfunction

    // live status byte; reading it is a pure function, so a query cannot disturb it
    logic [7:0] status_byte;
    logic       slot_ok;     // argument within 1..4
    logic [1:0] slot_idx;    // zero-based slot

    always_comb begin
        status_byte = sbsr_status_byte(state.mask, event_summary_i, message_avail_i, error_queue_i);
        slot_ok     = (cmd_arg_i >= sbsr_pkg::SLOT_MIN) && (cmd_arg_i <= sbsr_pkg::SLOT_MAX);
        slot_idx    = 2'(cmd_arg_i - sbsr_pkg::SLOT_MIN);
    end

    // next-state logic: command decode, acquisition tracking, answers
    always_comb begin
        next_state              = state;
        // strobes last one cycle
        next_state.resp_valid   = 1'b0;
        next_state.acq_start    = 1'b0;
        next_state.fetch_grant  = 1'b0;
        next_state.clear_status = 1'b0;
        // service request follows the masked status every cycle
        next_state.srq          = status_byte[sbsr_pkg::BIT_MSS];

        // sweep completion makes held data valid again
        if (state.acq == sbsr_pkg::ACQ_RUN && acq_done_i) begin
            next_state.data_valid = 1'b1;
            // continuous mode restarts at once, single mode goes idle
            if (state.cur.continuous) begin
                next_state.acq_start = 1'b1;
            end else begin
                next_state.acq = sbsr_pkg::ACQ_IDLE;
            end
        end

        if (cmd_valid_i) begin
            next_state.resp_valid = 1'b1;
            next_state.resp_data  = 16'h0000;
            next_state.resp_err   = sbsr_pkg::ERR_NONE;
            case (cmd_code_i)
                sbsr_pkg::CMD_RESET: begin
                    if (cmd_query_i) begin
                        // no query form exists; state left alone
                        next_state.resp_err = sbsr_pkg::ERR_ILLEGAL_FORM;
                    end else begin
                        next_state.cur           = sbsr_defaults();
                        next_state.acq           = sbsr_pkg::ACQ_IDLE;
                        next_state.data_valid    = 1'b0;
                        next_state.graphics      = 1'b0;
                        next_state.delta_mode    = 3'h0;
                        next_state.delta_ref_wl  = sbsr_pkg::DEF_DELTA_REF_WL;
                        next_state.drift         = 1'b0;
                        next_state.coherence     = 1'b0;
                        next_state.snr_meas      = 1'b0;
                        next_state.snr_user_wl   = sbsr_pkg::DEF_SNR_USER_WL;
                        next_state.uncorr_points = sbsr_pkg::DEF_UNCORR_PTS;
                        // mask deliberately untouched here
                    end
                end
                sbsr_pkg::CMD_SAVE: begin
                    if (cmd_query_i || !slot_ok) begin
                        next_state.resp_err = cmd_query_i ? sbsr_pkg::ERR_ILLEGAL_FORM
                                                          : sbsr_pkg::ERR_OUT_OF_RANGE;
                    end else begin
                        next_state.slot[slot_idx] = state.cur;
                    end
                end
                sbsr_pkg::CMD_RECALL: begin
                    if (cmd_query_i || !slot_ok) begin
                        next_state.resp_err = cmd_query_i ? sbsr_pkg::ERR_ILLEGAL_FORM
                                                          : sbsr_pkg::ERR_OUT_OF_RANGE;
                    end else begin
                        next_state.cur = state.slot[slot_idx];
                    end
                end
                sbsr_pkg::CMD_MASK: begin
                    if (cmd_query_i) begin
                        next_state.resp_data = {8'h00, state.mask};
                    end else begin
                        // bit 6 has no meaning in the mask and is never stored
                        next_state.mask = cmd_arg_i & ~(8'h01 << sbsr_pkg::BIT_MSS);
                    end
                end
                sbsr_pkg::CMD_STATUS: begin
                    // weighted sum is just the byte itself; nothing is cleared
                    next_state.resp_data = {8'h00, status_byte};
                end
                sbsr_pkg::CMD_CLEAR: begin
                    // event and error logic clear themselves; mask survives
                    next_state.clear_status = 1'b1;
                end
                sbsr_pkg::CMD_INITIATE: begin
                    // host starts a fresh sweep before fetching
                    next_state.acq       = sbsr_pkg::ACQ_RUN;
                    next_state.acq_start = 1'b1;
                end
                sbsr_pkg::CMD_FETCH: begin
                    if (state.data_valid) begin
                        next_state.fetch_grant = 1'b1;
                    end else begin
                        next_state.resp_err = sbsr_pkg::ERR_DATA_STALE;
                    end
                end
                sbsr_pkg::CMD_CONFIG: begin
                    next_state.cur = cfg_i;
                end
                default: begin
                    next_state.resp_err = sbsr_pkg::ERR_ILLEGAL_FORM;
                end
            endcase
        end
    end

    // single register stage; power-on clears the mask and the slots and loads the reset-command defaults
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            state               <= '0;
            state.mask          <= sbsr_pkg::MASK_RESET;
            state.acq           <= sbsr_pkg::ACQ_IDLE;
            state.cur           <= sbsr_defaults();
            state.delta_ref_wl  <= sbsr_pkg::DEF_DELTA_REF_WL;
            state.snr_user_wl   <= sbsr_pkg::DEF_SNR_USER_WL;
            state.uncorr_points <= sbsr_pkg::DEF_UNCORR_PTS;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    assign resp_valid_o    = state.resp_valid;
    assign resp_data_o     = state.resp_data;
    assign resp_err_o      = state.resp_err;
    assign srq_o           = state.srq;
    assign acq_start_o     = state.acq_start;
    assign fetch_grant_o   = state.fetch_grant;
    assign clear_status_o  = state.clear_status;
    assign settings_o      = state.cur;
    assign graphics_o      = state.graphics;
    assign delta_mode_o    = state.delta_mode;
    assign delta_ref_wl_o  = state.delta_ref_wl;
    assign drift_o         = state.drift;
    assign coherence_o     = state.coherence;
    assign snr_meas_o      = state.snr_meas;
    assign snr_user_wl_o   = state.snr_user_wl;
    assign uncorr_points_o = state.uncorr_points;
    assign data_valid_o    = state.data_valid;

endmodule

// ---- sbsr_checker.sv ----
// port assertions for the status and state block
`timescale 1ns/1ps
module sbsr_checker (
    input logic                     mclk_i,
    input logic                     resetn_i,
    input logic                     cmd_valid_i,
    input sbsr_pkg::sbsr_cmd_t      cmd_code_i,
    input logic                     cmd_query_i,
    input logic [7:0]               cmd_arg_i,
    input logic                     event_summary_i,
    input logic                     message_avail_i,
    input logic                     error_queue_i,
    input logic                     resp_valid_o,
    input logic [15:0]              resp_data_o,
    input logic [15:0]              resp_err_o,
    input logic                     srq_o,
    input logic                     acq_start_o,
    input logic                     fetch_grant_o,
    input sbsr_pkg::sbsr_settings_t settings_o,
    input logic                     snr_meas_o,
    input logic [15:0]              snr_user_wl_o,
    input logic [15:0]              uncorr_points_o,
    input logic                     data_valid_o
);
    logic [7:0]  mask; // shadow of the request mask, written by mask commands only
    logic [15:0] hot;  // one-hot of the command taken this cycle
    logic        ms;   // masked summary of the live status levels
    logic [7:0]  stb;  // status byte the block should report
    logic        rst;  // reset command in command form
    assign hot = cmd_valid_i ? 16'(16'h0001 << cmd_code_i) : 16'h0000;
    // the shadow ignores reset and clear commands, as the mask must
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            mask <= 8'h00;
        end else if (hot[sbsr_pkg::CMD_MASK] && !cmd_query_i) begin
            mask <= cmd_arg_i & 8'hBF;
        end
    end
    assign ms  = |({event_summary_i, message_avail_i, error_queue_i} & {mask[5], mask[4], mask[2]});
    assign stb = {1'b0, ms, event_summary_i, message_avail_i, 1'b0, error_queue_i, 2'b00};
    assign rst = hot[sbsr_pkg::CMD_RESET] && !cmd_query_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // srq lags the masked summary by one cycle
    srq_level_a:
        assert property ($past(resetn_i) |-> srq_o == $past(ms)) else $error("service request wrong");
    mask_read_a:
        assert property (hot[sbsr_pkg::CMD_MASK] && cmd_query_i
            |=> resp_valid_o && resp_data_o == {8'h00, $past(mask)}) else $error("mask read wrong");
    status_read_a:
        assert property (hot[sbsr_pkg::CMD_STATUS]
            |=> resp_valid_o && resp_data_o == {8'h00, $past(stb)}) else $error("status read wrong");
    reset_form_a:
        assert property (hot[sbsr_pkg::CMD_RESET] && cmd_query_i
            |=> resp_err_o == sbsr_pkg::ERR_ILLEGAL_FORM && $stable(settings_o)) else $error("reset query taken");
    slot_range_a:
        assert property (!cmd_query_i && (hot[sbsr_pkg::CMD_SAVE] || hot[sbsr_pkg::CMD_RECALL])
            && (cmd_arg_i < 8'h01 || cmd_arg_i > 8'h04)
            |=> resp_err_o == sbsr_pkg::ERR_OUT_OF_RANGE && $stable(settings_o)) else $error("bad slot taken");
    stale_fetch_a:
        assert property (hot[sbsr_pkg::CMD_FETCH] && !data_valid_o
            |=> resp_err_o == sbsr_pkg::ERR_DATA_STALE && !fetch_grant_o) else $error("stale fetch granted");
    reset_load_a:
        assert property (rst |=> !data_valid_o && !settings_o.continuous && settings_o.power_bar
            && settings_o.wl_start == sbsr_pkg::DEF_WL_START && settings_o.wl_stop == sbsr_pkg::DEF_WL_STOP)
        else $error("reset defaults wrong");
    snr_load_a:
        assert property (rst |=> !snr_meas_o && snr_user_wl_o == sbsr_pkg::DEF_SNR_USER_WL
            && settings_o.snr_avg_count == sbsr_pkg::DEF_SNR_AVG && uncorr_points_o == sbsr_pkg::DEF_UNCORR_PTS)
        else $error("noise defaults wrong");
    start_pulse_a:
        assert property (hot[sbsr_pkg::CMD_INITIATE] |=> acq_start_o ##0 resp_valid_o)
        else $error("no sweep start");
    // main scenarios reached
    cover property (hot[sbsr_pkg::CMD_MASK] && !cmd_query_i);
    cover property (hot[sbsr_pkg::CMD_STATUS] && ms);
    cover property (rst);
endmodule

bind sbsr_status_state sbsr_checker u_sbsr_checker (.*);

// ---- sbsr_host_model.sv ----
// bus controller model: issues one command and collects its answer
`timescale 1ns/1ps
module sbsr_host_model (
    input  logic                mclk_i,       // shared clock
    input  logic                resp_valid_i, // answer strobe
    input  logic [15:0]         resp_data_i,  // answer value
    input  logic [15:0]         resp_err_i,   // answer error code
    output logic                cmd_valid_o,  // command strobe
    output sbsr_pkg::sbsr_cmd_t cmd_code_o,   // command code
    output logic                cmd_query_o,  // query form
    output logic [7:0]          cmd_arg_o     // integer argument
);
    logic        got;  // answer strobe seen
    logic [15:0] data; // last answer value
    logic [15:0] err;  // last error code
    // code and argument mean nothing while the strobe is low
    initial cmd_valid_o = 1'b0;
    // refused forms are sent only when a test wants the refusal
    task automatic issue(input sbsr_pkg::sbsr_cmd_t c, input logic q, input logic [7:0] a);
        @(negedge mclk_i);
        cmd_valid_o = 1'b1;
        cmd_code_o  = c;
        cmd_query_o = q;
        cmd_arg_o   = a;
        @(negedge mclk_i);
        got  = resp_valid_i;
        data = resp_data_i;
        err  = resp_err_i;
        cmd_valid_o = 1'b0;
        cmd_arg_o   = ~a; // released argument lines do not keep the old value
    endtask
endmodule

// ---- tb_sbsr_status_state.sv ----
// self-checking bench for the status and state block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module tb_sbsr_status_state;
    logic                     mclk_i = 1'b0;      // 10 MHz clock
    logic                     resetn_i = 1'b0;    // power-on reset
    logic                     cmd_valid_i, cmd_query_i, resp_valid_o, srq_o, acq_start_o, fetch_grant_o;
    sbsr_pkg::sbsr_cmd_t      cmd_code_i;
    logic [7:0]               cmd_arg_i, m;       // argument, expected mask
    sbsr_pkg::sbsr_settings_t cfg_i = '0, settings_o, sv[1:4]; // per-slot copies
    logic                     event_summary_i = 1'b0, message_avail_i = 1'b0, error_queue_i = 1'b0;
    logic                     acq_done_i = 1'b0, clear_status_o, graphics_o, drift_o, coherence_o, snr_meas_o;
    logic                     data_valid_o;
    logic [2:0]               delta_mode_o;
    logic [15:0]              resp_data_o, resp_err_o, delta_ref_wl_o, snr_user_wl_o, uncorr_points_o;
    logic [127:0]             r;                  // random scratch
    integer                   seed = 32'h3AA7, fail_count = 0, num_checks = 0, i;
    always #50 mclk_i = ~mclk_i;
    sbsr_status_state u_sbsr_status_state (.*);
    sbsr_host_model u_host (.mclk_i, .resp_valid_i(resp_valid_o), .resp_data_i(resp_data_o),
        .resp_err_i(resp_err_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_query_o(cmd_query_i), .cmd_arg_o(cmd_arg_i));
    // expected status byte from the live levels and a mask
    function automatic logic [7:0] stb(input logic [7:0] k);
        logic ms;
        ms = |({event_summary_i, message_avail_i, error_queue_i} & {k[5], k[4], k[2]});
        return {1'b0, ms, event_summary_i, message_avail_i, 1'b0, error_queue_i, 2'b00};
    endfunction
    // every command gets its answer in the next cycle
    task automatic cmd(input sbsr_pkg::sbsr_cmd_t c, input logic q = 1'b0, input logic [7:0] v = 8'h00);
        u_host.issue(c, q, v);
        `CHK(u_host.got, 1'b1)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge mclk_i);
        resetn_i = 1'b1;
        cmd(sbsr_pkg::CMD_MASK, 1'b1);
        `CHK(u_host.data, 16'h0000)
        // random masks and levels; all-ones first so bit 6 must be dropped
        for (i = 0; i < 24; i++) begin
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            m = (i == 0) ? 8'hFF : r[7:0];
            {event_summary_i, message_avail_i, error_queue_i} = r[10:8];
            cmd(sbsr_pkg::CMD_MASK, 1'b0, m);
            m = m & 8'hBF;
            if (i[1]) cmd(sbsr_pkg::CMD_RESET);
            if (i[2]) begin
                cmd(sbsr_pkg::CMD_CLEAR);
                `CHK(clear_status_o, 1'b1)
            end
            cmd(sbsr_pkg::CMD_MASK, 1'b1);
            `CHK(u_host.data, {8'h00, m})
            cmd(sbsr_pkg::CMD_STATUS);
            `CHK(u_host.data, {8'h00, stb(m)})
            cmd(sbsr_pkg::CMD_STATUS);
            `CHK(u_host.data, {8'h00, stb(m)})
            `CHK(srq_o, stb(m) >= 8'h40)
        end
        $display("test mask and status finished");
        cmd(sbsr_pkg::CMD_RESET, 1'b1);
        `CHK(u_host.err, sbsr_pkg::ERR_ILLEGAL_FORM)
        cmd(sbsr_pkg::CMD_RESET);
        `CHK({data_valid_o, settings_o.wl_limit_en, settings_o.wl_start, settings_o.wl_stop}, {2'b01, sbsr_pkg::DEF_WL_START, sbsr_pkg::DEF_WL_STOP})
        `CHK({settings_o.peak_threshold, settings_o.peak_excursion, settings_o.power_offset, settings_o.elevation}, {sbsr_pkg::DEF_PEAK_THRESH, sbsr_pkg::DEF_PEAK_EXCUR, sbsr_pkg::DEF_POWER_OFFSET, sbsr_pkg::DEF_ELEVATION})
        `CHK({settings_o.continuous, settings_o.power_bar, settings_o.std_air, settings_o.fast_update, settings_o.display_mode, settings_o.freq_units, settings_o.power_units}, {4'h4, sbsr_pkg::DISP_SINGLE_WL, sbsr_pkg::UNIT_NM, sbsr_pkg::UNIT_DBM})
        `CHK({graphics_o, delta_mode_o, drift_o, coherence_o, delta_ref_wl_o}, {6'h00, sbsr_pkg::DEF_DELTA_REF_WL})
        `CHK({snr_meas_o, settings_o.snr_auto, snr_user_wl_o, settings_o.snr_avg_count, uncorr_points_o}, {2'b01, sbsr_pkg::DEF_SNR_USER_WL, sbsr_pkg::DEF_SNR_AVG, sbsr_pkg::DEF_UNCORR_PTS})
        cmd(sbsr_pkg::CMD_FETCH, 1'b1);
        `CHK({u_host.err, fetch_grant_o}, {sbsr_pkg::ERR_DATA_STALE, 1'b0})
        cmd(sbsr_pkg::CMD_INITIATE);
        `CHK(acq_start_o, 1'b1)
        acq_done_i = 1'b1;
        @(negedge mclk_i);
        acq_done_i = 1'b0;
        for (i = 0; i < 10 && !data_valid_o; i++) @(negedge mclk_i);
        if (!data_valid_o) begin
            fail_count++;
            report_and_stop();
        end
        cmd(sbsr_pkg::CMD_FETCH, 1'b1);
        `CHK({u_host.err, fetch_grant_o}, {sbsr_pkg::ERR_NONE, 1'b1})
        $display("test reset and fetch finished");
        // random settings into every slot, recalled in reverse with bad ends
        for (i = 1; i <= 5; i++) begin
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            cfg_i = r[$bits(cfg_i)-1:0];
            cmd(sbsr_pkg::CMD_CONFIG);
            if (i < 5) sv[i] = cfg_i;
            if (i < 5) cmd(sbsr_pkg::CMD_SAVE, 1'b0, i[7:0]);
        end
        for (i = 5; i >= 0; i--) begin
            cmd(sbsr_pkg::CMD_RECALL, 1'b0, i[7:0]);
            if (i == 0 || i == 5) `CHK(u_host.err, sbsr_pkg::ERR_OUT_OF_RANGE)
            else `CHK(settings_o, sv[i])
        end
        $display("test save and recall finished");
        report_and_stop();
    end
endmodule
